// File: bench/bpc_monitor.sv
// checker on the bias path controller top ports
// assumes one clock domain and the map in bpc_regs.svh
`timescale 1ns/1ps
`include "bpc_regs.svh"
module bpc_monitor (
  // clock, reset and apb
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  // levels and status
  input wire logic [15:0] vdd_mv_in,
  input wire logic [15:0] gate_bias_rail_mv_in,
  input wire logic [15:0] switched_bias_rail_mv_in,
  input wire logic        gate_bias_open_in,
  // controls
  input wire logic        startup_limit_resistor_high_out,
  input wire logic        switch_node_sense_pin_sw_out,
  input wire logic        gate_bias_rail_sw_out,
  input wire logic        reg13_sw_out,
  input wire logic        switched_bias_rail_sw_out,
  input wire logic        power_control_current_pin_en_out,
  input wire logic        low_side_pulse_out,
  input wire logic        fault_out
);
  logic run_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////
  // run bit shadowed from ctrl writes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_q <= 1'b0;
    end else if (psel_in && penable_in && pwrite_in && pstrb_in[0] &&
                 paddr_in == `BPC_CTRL_OFF) begin
      run_q <= pwdata_in[`BPC_CTRL_RUN_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////
  limit_track_a: assert property (
    $past(reset_n_in) && $past(switch_node_sense_pin_sw_out) && !$past(fault_out)
    |-> startup_limit_resistor_high_out == ($past(vdd_mv_in) <= `BPC_VDD_LOWR_MV))
    else $error("startup limit wrong");
  path_open_a: assert property (
    !fault_out && gate_bias_rail_sw_out && !gate_bias_open_in && vdd_mv_in >= `BPC_VDD_ON_MV
    |=> !gate_bias_rail_sw_out && !switch_node_sense_pin_sw_out) else $error("paths stay shut");
  reg_path_a: assert property (
    reg13_sw_out |-> !gate_bias_rail_sw_out && !switch_node_sense_pin_sw_out)
    else $error("regulator with startup paths");
  rail_hold_a: assert property (
    gate_bias_rail_sw_out |-> !switched_bias_rail_sw_out) else $error("rail on in startup");
  rail_off_a: assert property (
    !run_q |=> !switched_bias_rail_sw_out) else $error("rail on without run");
  pulse_gate_a: assert property (
    low_side_pulse_out |-> $past(switched_bias_rail_mv_in) > `BPC_S13_OK_MV)
    else $error("pulse before rail good");
  ov_fault_a: assert property (
    reg13_sw_out && run_q && gate_bias_rail_mv_in > `BPC_P13_OV_MV |=> fault_out)
    else $error("overvoltage missed");
  open_fault_a: assert property (
    gate_bias_rail_sw_out && !fault_out && gate_bias_open_in |=> fault_out)
    else $error("open bias missed");
  wait_off_a: assert property (
    !run_q |=> !power_control_current_pin_en_out) else $error("source on in wait");
  stop_off_a: assert property (
    vdd_mv_in < `BPC_VDD_SURV_MV |=> !power_control_current_pin_en_out)
    else $error("source on in survival");
endmodule
bind bpc_top bpc_monitor u_mon (.*);

// File: bench/bpc_rail_model.sv
// switched bias rail model: decoupling cap plus gan power ic load
// assumes sw_in comes straight from the controller's rail switch
`timescale 1ns/1ps
module bpc_rail_model (
  // clock
  input  wire logic        mclk_in,
  // rail switch
  input  wire logic        sw_in,
  // rail level in millivolts
  output logic      [15:0] rail_mv_out
);
  logic [15:0] rail_reg = 16'h0000;
  ////////////////////////////////////////////////////////////////
  // limited charge while switched on, load discharge while off
  always_ff @(posedge mclk_in) begin
    if (sw_in) begin
      rail_reg <= (rail_reg >= 16'h32c8) ? 16'h32c8 : rail_reg + 16'h01f4;
    end else begin
      rail_reg <= (rail_reg >= 16'h0064) ? rail_reg - 16'h0064 : 16'h0000;
    end
  end
  // load powers on at once, well inside the allowed delay
  assign rail_mv_out = rail_reg;
endmodule

// File: bench/bpc_top_tb.sv
// bench for the bias path controller top
// assumes bpc_rail_model stands on the switched rail
`timescale 1ns/1ps
`include "bpc_regs.svh"
module bpc_top_tb;
  import bpc_pkg::*;
  logic        mclk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic        gate_bias_open_in, demag_in, pulse_request_in, fault_out, int_stop_out, err;
  logic        startup_limit_resistor_high_out, switch_node_sense_pin_sw_out;
  logic        gate_bias_rail_sw_out, reg13_sw_out, switched_bias_rail_sw_out;
  logic        soft_start_en_out, power_control_current_pin_en_out, low_side_pulse_out;
  logic [3:0]  pstrb_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [15:0] vdd_mv_in, gate_bias_rail_mv_in, switched_bias_rail_mv_in;
  logic [15:0] aux_sense_pin_mv_in, sws_threshold_mv_out, prev;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  bpc_top u_dut (.*);
  bpc_rail_model u_rail (.mclk_in, .sw_in(switched_bias_rail_sw_out),
                         .rail_mv_out(switched_bias_rail_mv_in));
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic ctrl(input logic [31:0] d);
    apb(1'b1, `BPC_CTRL_OFF, d);
  endtask
  task automatic set_vdd(input logic [15:0] v);
    @(posedge mclk_in);
    vdd_mv_in <= v;
    step(2);
  endtask
  task automatic set_p13(input logic [15:0] v);
    @(posedge mclk_in);
    gate_bias_rail_mv_in <= v;
    step(2);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_start();
    chk(gate_bias_rail_sw_out, 1, "bias path");
    chk(switch_node_sense_pin_sw_out, 1, "sense path");
    chk(startup_limit_resistor_high_out, 1, "high limit");
    set_vdd(16'h0709);
    chk(startup_limit_resistor_high_out, 0, "low limit");
    ctrl(32'h0000_0001);
    set_vdd(16'h4267);
    chk(switched_bias_rail_sw_out, 0, "rail early");
    chk(gate_bias_rail_sw_out, 1, "below on");
    set_vdd(`BPC_VDD_ON_MV);
    chk(switch_node_sense_pin_sw_out, 0, "sense open");
    chk(gate_bias_rail_sw_out, 0, "bias open");
    chk(reg13_sw_out, 1, "reg path");
    chk(switched_bias_rail_sw_out, 1, "rail on");
    chk(soft_start_en_out, 1, "soft start");
    ctrl(32'h0000_0000);
    set_vdd(16'h3a98);
  endtask
  task automatic t_vset();
    ctrl(32'h0000_0002);
    step(2);
    chk(sws_threshold_mv_out, `BPC_SWS_HI_MV, "thr hi");
    apb(1'b0, `BPC_SENSE_OFF, 32'h0000_0000);
    chk(rd, `BPC_SWS_HI_MV, "sense reg");
    ctrl(32'h0000_0000);
    step(2);
    chk(sws_threshold_mv_out, `BPC_SWS_LO_MV, "thr lo");
  endtask
  task automatic t_rail();
    @(posedge mclk_in);
    pulse_request_in <= 1'b1;
    ctrl(32'h0000_0001);
    step(1);
    for (int i = 0; i < 60 && low_side_pulse_out !== 1'b1; i++) begin
      prev = switched_bias_rail_mv_in;
      step(1);
    end
    chk(prev > `BPC_S13_OK_MV && prev <= 16'h2904, 1, "pulse gate");
    ctrl(32'h0000_0000);
    step(2);
    chk(switched_bias_rail_sw_out, 0, "rail off");
    chk(soft_start_en_out, 0, "no drive");
    chk(low_side_pulse_out, 0, "pulse off");
    @(posedge mclk_in);
    pulse_request_in <= 1'b0;
  endtask
  task automatic nvo(input logic [15:0] v, input logic d, input logic exp);
    @(posedge mclk_in);
    aux_sense_pin_mv_in <= v;
    demag_in <= d;
    @(posedge mclk_in);
    demag_in <= 1'b0;
    apb(1'b0, `BPC_STATUS_OFF, 32'h0000_0000);
    chk(rd[`BPC_ST_LOWNVO_BIT], exp, "low flag");
  endtask
  task automatic t_ipc(input logic low);
    for (int m = 0; m < 5; m++) begin
      ctrl((32'(m) << `BPC_CTRL_MODE_LSB) | 32'h0000_0001);
      step(2);
      chk(power_control_current_pin_en_out, low | (m == int'(BPC_MODE_SB2)), "mode");
    end
    ctrl(32'h0000_0010);
    step(2);
    chk(power_control_current_pin_en_out, 0, "ipc wait");
  endtask
  task automatic t_stop();
    ctrl(32'h0000_0011);
    set_vdd(16'h32c7);
    chk(int_stop_out, 1, "stop");
    chk(power_control_current_pin_en_out, 0, "ipc stop");
    set_vdd(`BPC_VDD_SURV_MV);
    chk(int_stop_out, 0, "no stop");
    chk(power_control_current_pin_en_out, 1, "ipc back");
    set_vdd(16'h2968);
    chk(reg13_sw_out, 1, "at off level");
    set_vdd(16'h2967);
    chk(gate_bias_rail_sw_out, 1, "below off");
    set_vdd(`BPC_VDD_ON_MV);
    set_vdd(`BPC_VDD_SURV_MV);
  endtask
  task automatic t_fault();
    set_p13(`BPC_P13_OV_MV);
    chk(fault_out, 0, "at limit");
    set_p13(16'h3a99);
    chk(fault_out, 1, "overvoltage");
    set_p13(16'h32c8);
    ctrl(32'h0000_0111);
    step(2);
    chk(fault_out, 0, "cleared");
    set_vdd(16'h2af8);
    @(posedge mclk_in);
    gate_bias_open_in <= 1'b1;
    step(2);
    chk(fault_out, 1, "open bias");
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk(err, 1, "unmapped err");
    chk(rd, 0, "unmapped data");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    reset_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    pstrb_in = 4'hf;
    vdd_mv_in = 16'h0000;
    gate_bias_rail_mv_in = 16'h32c8;
    aux_sense_pin_mv_in = 16'h0bb8;
    gate_bias_open_in = 1'b0;
    demag_in = 1'b0;
    pulse_request_in = 1'b0;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    step(2);
    t_start();
    t_vset();
    t_rail();
    nvo(16'h095f, 1'b1, 1'b1);
    nvo(16'h0992, 1'b1, 1'b1);
    t_ipc(1'b1);
    nvo(16'h09c5, 1'b1, 1'b0);
    nvo(16'h07d0, 1'b0, 1'b0);
    nvo(16'h0960, 1'b1, 1'b0);
    t_ipc(1'b0);
    t_stop();
    t_fault();
    end_sim();
  end
endmodule

// File: rtl/bpc_nvo_det.sv
// low output voltage detector with hysteresis on the sampled aux sense
// assumes vs_mv is valid whenever demag is high
`timescale 1ns/1ps
`include "bpc_regs.svh"
module bpc_nvo_det (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  // detector link
  bpc_nvo_if.det    nvo
);
  logic low_output_voltage_flag_reg;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_output_voltage_flag_reg <= 1'b0;
    end else if (nvo.demag) begin
      if (nvo.vs_mv < `BPC_VS_LO_MV) begin
        low_output_voltage_flag_reg <= 1'b1;
      end else if (nvo.vs_mv > `BPC_VS_HI_MV) begin
        low_output_voltage_flag_reg <= 1'b0;
      end
      // in between keeps the old value
    end
  end
  assign nvo.low_output_voltage_flag = low_output_voltage_flag_reg;
endmodule

// File: rtl/bpc_top.sv
// bias path controller top: power paths, faults, switched rail and ipc source
// assumes analog levels arrive as millivolt words synchronous to mclk_in
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "bpc_regs.svh"
module bpc_top (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // analog levels in millivolts
  input  wire logic [15:0] vdd_mv_in,
  input  wire logic [15:0] gate_bias_rail_mv_in,
  input  wire logic [15:0] switched_bias_rail_mv_in,
  input  wire logic [15:0] aux_sense_pin_mv_in,
  // status from the analog front end
  input  wire logic        gate_bias_open_in,
  input  wire logic        demag_in,
  input  wire logic        pulse_request_in,
  // power path controls
  output logic             startup_limit_resistor_high_out,
  output logic             switch_node_sense_pin_sw_out,
  output logic             gate_bias_rail_sw_out,
  output logic             reg13_sw_out,
  output logic             switched_bias_rail_sw_out,
  output logic             soft_start_en_out,
  output logic      [15:0] sws_threshold_mv_out,
  output logic             power_control_current_pin_en_out,
  output logic             int_stop_out,
  output logic             low_side_pulse_out,
  output logic             fault_out
);
  import bpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  bpc_phase_t  phase_reg;
  bpc_phase_t  phase_next;
  logic        run_reg;
  logic        vset_reg;
  bpc_mode_t   mode_reg;
  logic        fault_open_reg;
  logic        fault_ov_reg;
  logic        high_r_reg;
  logic        startup_sw_reg;
  logic        reg13_reg;
  logic        s13_sw_reg;
  logic [15:0] sws_th_reg;
  logic        ipc_reg;
  logic        stop_reg;
  logic        pulse_reg;
  logic        s13_ok;
  logic        ipc_next;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        fclr;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic [31:0] prdata_reg;
  logic        ctrl_wr;
  logic        vdd_off;
  logic        vdd_surv;
  logic        p13_ov;

  bpc_nvo_if nvo_link ();

  assign nvo_link.demag = demag_in;
  assign nvo_link.vs_mv = aux_sense_pin_mv_in;

  bpc_nvo_det u_nvo (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .nvo        (nvo_link)
  );

  function automatic logic bpc_is_reg(input logic [11:0] a);
    bpc_is_reg = (a == `BPC_CTRL_OFF) || (a == `BPC_STATUS_OFF) || (a == `BPC_SENSE_OFF);
  endfunction

  function automatic logic bpc_below(input logic [15:0] lvl, input logic [15:0] lim);
    bpc_below = (lvl < lim);
  endfunction

  function automatic logic bpc_above(input logic [15:0] lvl, input logic [15:0] lim);
    bpc_above = (lvl > lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // level compares
  assign vdd_off  = bpc_below(vdd_mv_in, `BPC_VDD_OFF_MV);
  assign vdd_surv = bpc_below(vdd_mv_in, `BPC_VDD_SURV_MV);
  assign p13_ov   = bpc_above(gate_bias_rail_mv_in, `BPC_P13_OV_MV);
  assign s13_ok   = bpc_above(switched_bias_rail_mv_in, `BPC_S13_OK_MV);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign addr_ok     = bpc_is_reg(paddr_in);
  assign wr_en       = psel_in && penable_in && pwrite_in;
  assign rd_en       = psel_in && !penable_in && !pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign ctrl_wr     = wr_en && (paddr_in == `BPC_CTRL_OFF);
  assign fclr        = ctrl_wr && pstrb_in[1] && pwdata_in[`BPC_CTRL_FCLR_BIT];

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_reg  <= 1'b0;
      vset_reg <= 1'b0;
      mode_reg <= BPC_MODE_SB1;
    end else if (ctrl_wr && pstrb_in[0]) begin
      run_reg  <= pwdata_in[`BPC_CTRL_RUN_BIT];
      vset_reg <= pwdata_in[`BPC_CTRL_VSET_BIT];
      mode_reg <= bpc_mode_t'(pwdata_in[`BPC_CTRL_MODE_LSB +: `BPC_CTRL_MODE_W]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup sequence and faults
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      BPC_STARTUP: begin
        if (gate_bias_open_in) begin
          phase_next = BPC_FAULT;
        end else if (vdd_mv_in >= `BPC_VDD_ON_MV) begin
          phase_next = BPC_ACTIVE;
        end
      end
      BPC_ACTIVE: begin
        if (run_reg && p13_ov) begin
          phase_next = BPC_FAULT;
        end else if (vdd_off) begin
          phase_next = BPC_STARTUP;
        end
      end
      BPC_FAULT: begin
        if (fclr || vdd_off) begin
          phase_next = BPC_STARTUP;
        end
      end
      default: phase_next = BPC_STARTUP;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_reg <= BPC_STARTUP;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_open_reg <= 1'b0;
    end else if (phase_reg == BPC_STARTUP && gate_bias_open_in) begin
      fault_open_reg <= 1'b1;
    end else if (fclr) begin
      fault_open_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_ov_reg <= 1'b0;
    end else if (phase_reg == BPC_ACTIVE && run_reg && p13_ov) begin
      fault_ov_reg <= 1'b1;
    end else if (fclr) begin
      fault_ov_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power path switches
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      high_r_reg <= 1'b1;
    end else begin
      high_r_reg <= !bpc_above(vdd_mv_in, `BPC_VDD_LOWR_MV);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      startup_sw_reg <= 1'b1;
    end else begin
      startup_sw_reg <= (phase_next == BPC_STARTUP);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg13_reg <= 1'b0;
    end else begin
      reg13_reg <= (phase_next == BPC_ACTIVE);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sws_th_reg <= `BPC_SWS_LO_MV;
    end else begin
      sws_th_reg <= vset_reg ? `BPC_SWS_HI_MV : `BPC_SWS_LO_MV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switched bias rail and low side pulse gating

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s13_sw_reg <= 1'b0;
    end else begin
      // open while run low leaves the rail to its loads
      s13_sw_reg <= run_reg && (phase_next == BPC_ACTIVE);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_reg <= 1'b0;
    end else begin
      // rail load assumed up within the power-good margin
      pulse_reg <= s13_sw_reg && s13_ok && pulse_request_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control current source
  always_comb begin
    ipc_next = 1'b0;
    if (phase_reg == BPC_ACTIVE && run_reg && !stop_reg) begin
      if (nvo_link.low_output_voltage_flag) begin
        ipc_next = (mode_reg == BPC_MODE_SB1) || (mode_reg == BPC_MODE_SB2) ||
                   (mode_reg == BPC_MODE_LPM) || (mode_reg == BPC_MODE_ABM) ||
                   (mode_reg == BPC_MODE_AAM);
      end else begin
        ipc_next = (mode_reg == BPC_MODE_SB2);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= (phase_reg == BPC_ACTIVE) && vdd_surv;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ipc_reg <= 1'b0;
    end else begin
      ipc_reg <= ipc_next && !vdd_surv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`BPC_ST_PHASE_LSB +: 2] = phase_reg;
    status_word[`BPC_ST_HIGHR_BIT]  = high_r_reg;
    status_word[`BPC_ST_SWS_BIT]    = startup_sw_reg;
    status_word[`BPC_ST_P13SW_BIT]  = startup_sw_reg;
    status_word[`BPC_ST_REG13_BIT]  = reg13_reg;
    status_word[`BPC_ST_S13SW_BIT]  = s13_sw_reg;
    status_word[`BPC_ST_VSET_BIT]   = vset_reg;
    status_word[`BPC_ST_LOWNVO_BIT] = nvo_link.low_output_voltage_flag;
    status_word[`BPC_ST_STOP_BIT]   = stop_reg;
    status_word[`BPC_ST_IPC_BIT]    = ipc_reg;
    status_word[`BPC_ST_FOPEN_BIT]  = fault_open_reg;
    status_word[`BPC_ST_FOV_BIT]    = fault_ov_reg;
    status_word[`BPC_ST_PULSE_BIT]  = pulse_reg;
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr_in)
      `BPC_CTRL_OFF: begin
        rdata_next[`BPC_CTRL_RUN_BIT]  = run_reg;
        rdata_next[`BPC_CTRL_VSET_BIT] = vset_reg;
        rdata_next[`BPC_CTRL_MODE_LSB +: `BPC_CTRL_MODE_W] = mode_reg;
      end
      `BPC_STATUS_OFF: rdata_next = status_word;
      `BPC_SENSE_OFF:  rdata_next = {16'h0000, sws_th_reg};
      default:         rdata_next = 32'h0000_0000;
    endcase
  end

  // read word captured in the setup cycle, stands through the access cycle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= rd_en ? rdata_next : 32'h0000_0000;
    end
  end

  assign prdata_out = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign startup_limit_resistor_high_out  = high_r_reg;
  assign switch_node_sense_pin_sw_out     = startup_sw_reg;
  assign gate_bias_rail_sw_out            = startup_sw_reg;
  assign reg13_sw_out                     = reg13_reg;
  assign switched_bias_rail_sw_out        = s13_sw_reg;
  assign soft_start_en_out                = s13_sw_reg;
  assign sws_threshold_mv_out             = sws_th_reg;
  assign power_control_current_pin_en_out = ipc_reg;
  assign int_stop_out                     = stop_reg;
  assign low_side_pulse_out               = pulse_reg;
  assign fault_out                        = (phase_reg == BPC_FAULT);
endmodule

// File: shared/bpc_nvo_if.sv
// link between the top and the output voltage detector
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface bpc_nvo_if;
  logic        demag;
  logic [15:0] vs_mv;
  logic        low_output_voltage_flag;
  modport top (output demag, output vs_mv, input low_output_voltage_flag);
  modport det (input demag, input vs_mv, output low_output_voltage_flag);
endinterface

// File: shared/bpc_pkg.sv
// bias path controller types
// assumes bpc_regs.svh for numeric constants
package bpc_pkg;
  typedef enum logic [1:0] {
    BPC_STARTUP,
    BPC_ACTIVE,
    BPC_FAULT
  } bpc_phase_t;
  typedef enum logic [2:0] {
    BPC_MODE_SB1,
    BPC_MODE_SB2,
    BPC_MODE_LPM,
    BPC_MODE_ABM,
    BPC_MODE_AAM
  } bpc_mode_t;
endpackage

// File: shared/bpc_regs.svh
// bias path controller: register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned registers
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH
`define BPC_CTRL_OFF        12'h000
`define BPC_STATUS_OFF      12'h004
`define BPC_SENSE_OFF       12'h008
// ctrl fields
`define BPC_CTRL_RUN_BIT    0
`define BPC_CTRL_VSET_BIT   1
`define BPC_CTRL_MODE_LSB   4
`define BPC_CTRL_MODE_W     3
`define BPC_CTRL_FCLR_BIT   8
`define BPC_CTRL_RST        32'h0000_0000
// status fields
`define BPC_ST_PHASE_LSB    0
`define BPC_ST_HIGHR_BIT    2
`define BPC_ST_SWS_BIT      3
`define BPC_ST_P13SW_BIT    4
`define BPC_ST_REG13_BIT    5
`define BPC_ST_S13SW_BIT    6
`define BPC_ST_VSET_BIT     7
`define BPC_ST_LOWNVO_BIT   8
`define BPC_ST_STOP_BIT     9
`define BPC_ST_IPC_BIT      10
`define BPC_ST_FOPEN_BIT    11
`define BPC_ST_FOV_BIT      12
`define BPC_ST_PULSE_BIT    13
// analog thresholds in millivolts
`define BPC_VDD_LOWR_MV     16'd1800
`define BPC_VDD_ON_MV       16'd17000
`define BPC_VDD_OFF_MV      16'd10600
`define BPC_VDD_SURV_MV     16'd13000
`define BPC_P13_OV_MV       16'd15000
`define BPC_S13_OK_MV       16'd10000
`define BPC_VS_LO_MV        16'd2400
`define BPC_VS_HI_MV        16'd2500
`define BPC_SWS_HI_MV       16'd8500
`define BPC_SWS_LO_MV       16'd4000
// gan power-on allowance
`define BPC_GAN_PON_NS      2000
`define BPC_CLK_NS          4
`define BPC_GAN_PON_CYC     (`BPC_GAN_PON_NS / `BPC_CLK_NS)
`endif
